/* cycle_counter.sv */
// Restartable up-counter that flags the last cycle of a programmed period.
// Assumes restart on every entry into a timed phase.
`timescale 1ns/1ps
module cycle_counter
   import reset_strap_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic restart,
   input wire logic [CNT_W-1:0] limit,
   output logic last
);

   logic [CNT_W-1:0] count;

   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         count <= '0;
      end else if (!last) begin
         count <= count + 10'h001;
      end
   end

   assign last = (count == limit - 10'h001);

endmodule // cycle_counter

/* reset_control_and_mode_strap.sv */
// Reset sequencer with reset pin stretching, power-on lock wait and strap capture.
// Assumes all pin inputs synchronous to aclk and an external pull-up on the reset line.
//
// Contract
// - Reset is recognised only when the clock samples the reset pin low.
// - Ordinary resets wait for bus cycle end; catastrophic ones act at once.
// - Reset outranks everything; work in progress is dropped, not resumed.
// - Validate, assert controls, apply straps, then hand control to processor.
// - Straps sampled during reset; high gives default, low gives alternate function.
// - Decode boot width, chip select alternates, port E, port F, test mode.
// - Clock strap high selects synthesizer, low selects external clock input.
// - Breakpoint strap low enables background debug, high leaves it disabled.
// - Peripheral pins out of reset are inputs; pwm outputs discrete, receive kept.
// - During reset unit pins are disabled or inactive.
// - After external reset, drive pin low 512 cycles from its release.
// - Internal reset drives pin at least 512 cycles, longer while source holds.
// - After each drive, release pin 10 cycles then test; high starts processing.
// - Pin still low after release window means another drive and retest.
// - Power-on holds internal and external reset; pins initialised then.
// - With synthesizer, external reset holds until lock plus 512 cycles.
// - Internal reset held four cycles before other modules leave reset.
// - Port E strap loads all eight port E assignment bits.
// - Port F strap loads all eight port F assignment bits.
`timescale 1ns/1ps
module reset_control_and_mode_strap
   import reset_strap_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Open-drain reset pin
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe_n,
   // Reset sources and system status
   input wire logic bus_cycle_end,
   input wire logic internal_reset_req,
   input wire logic async_reset_req,
   input wire logic pll_lock,
   // Strap pins
   input wire logic [STRAP_W-1:0] data_strap,
   input wire logic clock_source_strap,
   input wire logic breakpoint_strap,
   // Reset outputs
   output logic intermodule_bus_reset_n,
   output logic cpu_reset_n,
   output logic reset_exception_start,
   output logic sim_pins_oe_n,
   // Configuration outputs
   output logic boot_chip_select_8bit,
   output logic [STRAP_CS_HI-STRAP_CS_LO:0] cs_alternate_select,
   output logic [PORT_W-1:0] port_e_assignment_bits,
   output logic [PORT_W-1:0] port_f_assignment_bits,
   output logic test_mode_enable,
   output logic external_clock_select,
   output logic background_debug_enable,
   output logic [PERIPH_DIR_W-1:0] periph_direction,
   output logic pwm_outputs_discrete,
   output logic serial_receive_enable
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   reset_state_e state, next_state;
   logic pending_ext, pending_int;
   logic sw_reset_pulse;
   logic [CNT_W-1:0] phase_limit;
   logic phase_last;
   logic phase_restart;
   logic drive_pin;
   logic in_reset;
   logic [STRAP_W-1:0] strap_latch;
   logic clock_latch, breakpoint_latch;
   logic [7:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic do_write;
   logic [31:0] read_word;
   logic read_ok;
   logic write_ok;

   // ****************************************************************
   // Pending ordinary resets
   // ****************************************************************
   // Pin seen only on clock edges: no clock, no reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending_ext <= 1'b0;
      end else if (state == ST_RUN && !reset_pin_in) begin
         pending_ext <= 1'b1;
      end else if (state != ST_RUN) begin
         pending_ext <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pending_int <= 1'b0;
      end else if (state == ST_RUN && (internal_reset_req || sw_reset_pulse)) begin
         pending_int <= 1'b1;
      end else if (state != ST_RUN) begin
         pending_int <= 1'b0;
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_POWER_ON;
      end else begin
         state <= next_state;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_POWER_ON: begin
            // Limp rate until lock; external clock skips it
            if (pll_lock || !clock_source_strap) begin
               next_state = ST_DRIVE;
            end
         end
         ST_RUN: begin
            // Let writes in flight finish
            if ((pending_ext || !reset_pin_in) && bus_cycle_end) begin
               next_state = ST_EXT_WAIT;
            end else if ((pending_int || internal_reset_req || sw_reset_pulse) && bus_cycle_end) begin
               next_state = ST_DRIVE;
            end
         end
         ST_EXT_WAIT: begin
            if (reset_pin_in) begin
               next_state = ST_DRIVE;
            end
         end
         ST_DRIVE: begin
            if (phase_last) begin
               if (internal_reset_req || async_reset_req) begin
                  next_state = ST_INT_HOLD;
               end else begin
                  next_state = ST_RELEASE;
               end
            end
         end
         ST_INT_HOLD: begin
            if (!internal_reset_req && !async_reset_req) begin
               next_state = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            if (phase_last) begin
               if (reset_pin_in) begin
                  next_state = ST_MODULE_HOLD;
               end else begin
                  next_state = ST_DRIVE;
               end
            end
         end
         ST_MODULE_HOLD: begin
            if (phase_last) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_POWER_ON;
         end
      endcase
      // Catastrophic reset acts on any edge
      if (async_reset_req && state != ST_DRIVE && state != ST_INT_HOLD && state != ST_POWER_ON) begin
         next_state = ST_DRIVE;
      end
   end

   // ****************************************************************
   // Phase timing
   // ****************************************************************
   always_comb begin
      case (state)
         ST_RELEASE: phase_limit = RELEASE_CYCLES;
         ST_MODULE_HOLD: phase_limit = MODULE_HOLD_CYCLES;
         default: phase_limit = DRIVE_CYCLES;
      endcase
   end

   assign phase_restart = (next_state != state);

   cycle_counter phase_counter (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(phase_restart),
      .limit(phase_limit),
      .last(phase_last)
   );

   // ****************************************************************
   // Reset pin and reset outputs
   // ****************************************************************
   // Registered so the line never glitches
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive_pin <= 1'b1;
      end else begin
         drive_pin <= (next_state == ST_POWER_ON || next_state == ST_DRIVE
                       || next_state == ST_INT_HOLD);
      end
   end

   assign reset_pin_out = 1'b0;
   assign reset_pin_oe_n = !drive_pin;
   assign in_reset = (next_state != ST_RUN);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         intermodule_bus_reset_n <= 1'b0;
         cpu_reset_n <= 1'b0;
         sim_pins_oe_n <= 1'b1;
         reset_exception_start <= 1'b0;
      end else begin
         intermodule_bus_reset_n <= (next_state == ST_RUN);
         cpu_reset_n <= (next_state == ST_RUN);
         sim_pins_oe_n <= (next_state != ST_RUN);
         reset_exception_start <= (state == ST_MODULE_HOLD && next_state == ST_RUN);
      end
   end

   // ****************************************************************
   // Strap capture and decode
   // ****************************************************************
   // Captured where the release test passes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_latch <= '1;
         clock_latch <= 1'b1;
         breakpoint_latch <= 1'b1;
      end else if (state == ST_RELEASE && next_state == ST_MODULE_HOLD) begin
         strap_latch <= data_strap;
         clock_latch <= clock_source_strap;
         breakpoint_latch <= breakpoint_strap;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_chip_select_8bit <= 1'b0;
         cs_alternate_select <= '0;
         test_mode_enable <= 1'b0;
         external_clock_select <= 1'b0;
         background_debug_enable <= 1'b0;
      end else begin
         boot_chip_select_8bit <= !strap_latch[STRAP_BOOT_WIDTH];
         cs_alternate_select <= ~strap_latch[STRAP_CS_HI:STRAP_CS_LO];
         test_mode_enable <= !strap_latch[STRAP_TEST];
         external_clock_select <= !clock_latch;
         background_debug_enable <= !breakpoint_latch;
      end
   end

   // ****************************************************************
   // Register bus, write side
   // ****************************************************************
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_comb begin
      case ({aw_addr[7:2], 2'h0})
         ADDR_CONTROL, ADDR_PORT_E_ASSIGN, ADDR_PORT_F_ASSIGN, ADDR_PERIPH_DIR: write_ok = 1'b1;
         ADDR_STATUS, ADDR_CONFIG: write_ok = 1'b1;
         default: write_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= write_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Software reset: one-cycle internal source
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_reset_pulse <= 1'b0;
      end else begin
         sw_reset_pulse <= do_write && ({aw_addr[7:2], 2'h0} == ADDR_CONTROL)
                           && w_strb[0] && w_data[CTRL_SW_RESET];
      end
   end

   // Loaded from straps, then software writable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_e_assignment_bits <= '1;
      end else if (state == ST_RELEASE && next_state == ST_MODULE_HOLD) begin
         port_e_assignment_bits <= {PORT_W{data_strap[STRAP_PORT_E]}};
      end else if (do_write && ({aw_addr[7:2], 2'h0} == ADDR_PORT_E_ASSIGN) && w_strb[0]) begin
         port_e_assignment_bits <= w_data[PORT_W-1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_f_assignment_bits <= '1;
      end else if (state == ST_RELEASE && next_state == ST_MODULE_HOLD) begin
         port_f_assignment_bits <= {PORT_W{data_strap[STRAP_PORT_F]}};
      end else if (do_write && ({aw_addr[7:2], 2'h0} == ADDR_PORT_F_ASSIGN) && w_strb[0]) begin
         port_f_assignment_bits <= w_data[PORT_W-1:0];
      end
   end

   // Inputs from the reset edge on; writes then are dropped
   always_ff @(posedge aclk) begin
      if (!aresetn || in_reset) begin
         periph_direction <= PERIPH_DIR_RESET;
         pwm_outputs_discrete <= 1'b1;
         serial_receive_enable <= 1'b1;
      end else if (do_write && ({aw_addr[7:2], 2'h0} == ADDR_PERIPH_DIR)) begin
         if (w_strb[0]) begin
            periph_direction[7:0] <= w_data[7:0];
         end
         if (w_strb[1]) begin
            periph_direction[15:8] <= w_data[15:8];
         end
      end
   end

   // ****************************************************************
   // Register bus, read side
   // ****************************************************************
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      read_word = '0;
      read_ok = 1'b1;
      case ({s_axi_araddr[7:2], 2'h0})
         ADDR_CONTROL: read_word = '0;
         ADDR_STATUS: read_word = {26'h0, pll_lock, drive_pin, pending_ext | pending_int, state};
         ADDR_PORT_E_ASSIGN: read_word = {24'h0, port_e_assignment_bits};
         ADDR_PORT_F_ASSIGN: read_word = {24'h0, port_f_assignment_bits};
         ADDR_PERIPH_DIR: read_word = {16'h0, periph_direction};
         ADDR_CONFIG: read_word = {18'h0, breakpoint_latch, clock_latch, strap_latch};
         default: read_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= read_word;
         s_axi_rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // reset_control_and_mode_strap

/* reset_line_partner.sv */
// Other devices sharing the open-drain reset line, with the line's pull-up.
// Assumes the bench raises pull_cmd just after a rising clock edge.
`timescale 1ns/1ps
module reset_line_partner #(
   parameter int MIN_HOLD = 8
) (
   input wire logic aclk,
   input wire logic pull_cmd,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe_n,
   output logic reset_line
);
   int hold_cnt = 0;
   // Stretch short requests to the minimum hold
   always @(posedge aclk) begin
      if (pull_cmd) begin
         hold_cnt <= MIN_HOLD;
      end else if (hold_cnt > 0) begin
         hold_cnt <= hold_cnt - 1;
      end
   end
   // Pull-up wins unless some party pulls low
   assign reset_line = !(pull_cmd || hold_cnt > 0 || (!reset_pin_oe_n && !reset_pin_out));
endmodule // reset_line_partner

/* reset_strap_pkg.sv */
// Constants, register map and state encoding of the reset controller.
// Assumes a single 25 MHz clock domain and a 32-bit AXI4-Lite register bus.
package reset_strap_pkg;

   // ****************************************************************
   // Sequence timing in clock cycles
   // ****************************************************************
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] DRIVE_CYCLES = 10'h200;
   localparam logic [CNT_W-1:0] RELEASE_CYCLES = 10'h00a;
   localparam logic [CNT_W-1:0] MODULE_HOLD_CYCLES = 10'h004;

   // ****************************************************************
   // Strap pin positions on the sampled data bus
   // ****************************************************************
   localparam int STRAP_W = 12;
   localparam int STRAP_BOOT_WIDTH = 0;
   localparam int STRAP_CS_LO = 1;
   localparam int STRAP_CS_HI = 7;
   localparam int STRAP_PORT_E = 8;
   localparam int STRAP_PORT_F = 9;
   localparam int STRAP_TEST = 11;
   localparam int PORT_W = 8;
   localparam int PERIPH_DIR_W = 16;

   // ****************************************************************
   // Register map, byte addresses
   // ****************************************************************
   localparam logic [7:0] ADDR_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_PORT_E_ASSIGN = 8'h08;
   localparam logic [7:0] ADDR_PORT_F_ASSIGN = 8'h0c;
   localparam logic [7:0] ADDR_PERIPH_DIR = 8'h10;
   localparam logic [7:0] ADDR_CONFIG = 8'h14;
   localparam int CTRL_SW_RESET = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [PERIPH_DIR_W-1:0] PERIPH_DIR_RESET = 16'h0000;

   // ****************************************************************
   // Reset sequencer states, Gray coded from ST_RUN through ST_EXT_WAIT, ST_DRIVE and ST_RELEASE to ST_MODULE_HOLD
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_RUN = 3'h0,
      ST_EXT_WAIT = 3'h1,
      ST_DRIVE = 3'h3,
      ST_RELEASE = 3'h2,
      ST_MODULE_HOLD = 3'h6,
      ST_INT_HOLD = 3'h7,
      ST_POWER_ON = 3'h4
   } reset_state_e;

endpackage

/* reset_strap_props.sv */
// Checker on the reset sequencer ports.
// Assumes one clock domain and binding onto the top module.
`timescale 1ns/1ps
module reset_strap_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic reset_pin_in,
   input wire logic reset_pin_oe_n,
   input wire logic bus_cycle_end,
   input wire logic async_reset_req,
   input wire logic [11:0] data_strap,
   input wire logic clock_source_strap,
   input wire logic breakpoint_strap,
   input wire logic intermodule_bus_reset_n,
   input wire logic cpu_reset_n,
   input wire logic reset_exception_start,
   input wire logic sim_pins_oe_n,
   input wire logic [7:0] port_e_assignment_bits,
   input wire logic [7:0] port_f_assignment_bits,
   input wire logic test_mode_enable,
   input wire logic external_clock_select,
   input wire logic background_debug_enable,
   input wire logic [15:0] periph_direction,
   input wire logic pwm_outputs_discrete,
   input wire logic serial_receive_enable
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [9:0] low_cnt;
   // Saturating count of device drive cycles
   always_ff @(posedge aclk) begin
      if (!aresetn || reset_pin_oe_n) begin
         low_cnt <= 10'h000;
      end else if (low_cnt != 10'h3ff) begin
         low_cnt <= low_cnt + 10'h001;
      end
   end
   chk_pins_idle: assert property (!cpu_reset_n |-> sim_pins_oe_n)
      else $error("unit pins active during reset");
   chk_ports_input: assert property (!cpu_reset_n |-> periph_direction == 16'h0000 && pwm_outputs_discrete
      && serial_receive_enable)
      else $error("peripheral pins not reset");
   chk_bus_wait: assert property (cpu_reset_n && !bus_cycle_end && !async_reset_req |=> cpu_reset_n)
      else $error("reset began inside a bus cycle");
   chk_async_now: assert property (cpu_reset_n && async_reset_req |=> !reset_pin_oe_n && !cpu_reset_n)
      else $error("catastrophic reset late");
   chk_drive_len: assert property ($rose(reset_pin_oe_n) |-> low_cnt >= 10'h200)
      else $error("reset line drive too short");
   chk_release_hold: assert property ($rose(cpu_reset_n) |-> $past(reset_pin_oe_n, 14)
      && !$past(reset_pin_oe_n, 15))
      else $error("release or hold length wrong");
   chk_test_high: assert property ($rose(cpu_reset_n) |-> $past(reset_pin_in, 5))
      else $error("processing began with line low");
   chk_retry_drive: assert property (!cpu_reset_n && $rose(reset_pin_oe_n) ##9 !reset_pin_in
      |=> !reset_pin_oe_n)
      else $error("no new drive after failed test");
   chk_port_straps: assert property ($rose(cpu_reset_n) |-> port_e_assignment_bits == {8{$past(data_strap[8], 5)}}
      && port_f_assignment_bits == {8{$past(data_strap[9], 5)}})
      else $error("port assignment not loaded from straps");
   chk_mode_straps: assert property (
      $rose(cpu_reset_n) |-> external_clock_select == !$past(clock_source_strap, 5)
      && background_debug_enable == !$past(breakpoint_strap, 5) && test_mode_enable == !$past(data_strap[11], 5))
      else $error("mode decode wrong");
   chk_config_hold: assert property (cpu_reset_n && $past(cpu_reset_n) |-> $stable(test_mode_enable)
      && $stable(external_clock_select) && $stable(background_debug_enable))
      else $error("configuration changed outside reset");
   chk_start_pulse: assert property (reset_exception_start |-> $rose(cpu_reset_n))
      else $error("start pulse without hand-over");
   chk_twin_reset: assert property (intermodule_bus_reset_n == cpu_reset_n)
      else $error("module and processor resets differ");
endmodule // reset_strap_props

bind reset_control_and_mode_strap reset_strap_props u_props (.*);

/* testbench.sv */
// Bench: power-on, register, internal, external, software and catastrophic resets.
// Assumes the partner model holds the reset line's pull-up.
`timescale 1ns/1ps
module testbench;
   import reset_strap_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reset_pin_in, reset_pin_out, reset_pin_oe_n;
   logic bus_cycle_end, internal_reset_req, async_reset_req, pll_lock, clock_source_strap, breakpoint_strap;
   logic intermodule_bus_reset_n, cpu_reset_n, reset_exception_start, sim_pins_oe_n, boot_chip_select_8bit;
   logic test_mode_enable, external_clock_select, background_debug_enable, pwm_outputs_discrete;
   logic serial_receive_enable, ext_pull;
   logic [7:0] s_axi_awaddr, s_axi_araddr, port_e_assignment_bits, port_f_assignment_bits;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [11:0] data_strap;
   logic [6:0] cs_alternate_select;
   logic [15:0] periph_direction;
   int miscompares, tests_run, c, n;
   reset_control_and_mode_strap DUT (.*);
   reset_line_partner PARTNER (.aclk, .pull_cmd(ext_pull), .reset_pin_out, .reset_pin_oe_n, .reset_line(reset_pin_in));
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task check(input string name, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", name, e, g);
         miscompares++;
      end
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ****************************************************************
   // Bus and wait helpers
   // ****************************************************************
   task axi_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 200 && s_axi_bvalid !== 1'b1; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task axi_read(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 200 && s_axi_rvalid !== 1'b1; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task wait_run;
      for (c = 0; c < 3000 && cpu_reset_n !== 1'b1; c++) @(posedge aclk);
      check("run reached", 1, c < 3000);
   endtask
   // Length of the next device drive
   task measure;
      for (n = 0; n < 3000 && reset_pin_oe_n !== 1'b0; n++) @(posedge aclk);
      for (c = 0; c < 3000 && reset_pin_oe_n === 1'b0; c++) @(posedge aclk);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task power_on;
      repeat (600) @(posedge aclk);
      check("held before lock", 0, reset_pin_in);
      pll_lock <= 1'b1;
      wait_run;
      check("lock wait", 1, c >= 526);
      check("boot width", 1, boot_chip_select_8bit);
      check("cs alternates", 32'h52, cs_alternate_select);
      check("port e", 0, port_e_assignment_bits);
      check("port f", 32'hff, port_f_assignment_bits);
      check("test mode", 1, test_mode_enable);
      check("clock select", 0, external_clock_select);
      check("debug", 1, background_debug_enable);
   endtask
   task regs;
      axi_read(ADDR_CONFIG);
      check("config", 32'h125a, rd);
      axi_write(ADDR_PERIPH_DIR, 32'h0000a5c3);
      check("dir write", 32'ha5c3, periph_direction);
      axi_read(8'h20);
      check("unmapped resp", RESP_SLVERR, rs);
      check("unmapped data", 0, rd);
      axi_read(ADDR_STATUS);
      check("status", 32'h20, rd);
   endtask
   task int_reset;
      data_strap <= 12'hb00;
      breakpoint_strap <= 1'b1;
      internal_reset_req <= 1'b1;
      bus_cycle_end <= 1'b0;
      repeat (20) @(posedge aclk);
      check("waits for bus end", 1, cpu_reset_n);
      bus_cycle_end <= 1'b1;
      repeat (700) @(posedge aclk);
      check("held while source", 0, reset_pin_in);
      check("dir cleared", 0, periph_direction);
      check("pins off", 1, sim_pins_oe_n);
      internal_reset_req <= 1'b0;
      wait_run;
      check("cs reloaded", 32'h7f, cs_alternate_select);
      check("port e reloaded", 32'hff, port_e_assignment_bits);
      check("debug off", 0, background_debug_enable);
   endtask
   task ext_reset;
      ext_pull <= 1'b1;
      repeat (50) @(posedge aclk);
      ext_pull <= 1'b0;
      measure;
      check("stretch length", 512, c);
      ext_pull <= 1'b1;
      repeat (5) @(posedge aclk);
      ext_pull <= 1'b0;
      measure;
      check("retry length", 512, c);
      wait_run;
   endtask
   task sw_async;
      axi_write(ADDR_CONTROL, 32'h1);
      check("control resp", RESP_OKAY, rs);
      measure;
      check("internal length", 1, c >= 512);
      wait_run;
      check("straps kept", 0, test_mode_enable);
      async_reset_req <= 1'b1;
      bus_cycle_end <= 1'b0;
      repeat (2) @(posedge aclk);
      check("async drive", 0, reset_pin_oe_n);
      async_reset_req <= 1'b0;
      bus_cycle_end <= 1'b1;
      wait_run;
   endtask
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      {aresetn, internal_reset_req, async_reset_req, pll_lock, ext_pull, breakpoint_strap} = 6'h00;
      bus_cycle_end = 1'b1;
      clock_source_strap = 1'b1;
      data_strap = 12'h25a;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      power_on;
      regs;
      int_reset;
      ext_reset;
      sw_async;
      test_done;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      test_done;
   end
endmodule // testbench
